// >>> verilog/tx_alarm_regs.vh
/*
  Constants for the latched transmitter alarm flag bytes: byte offsets,
  field positions, reset values and timing figures.
  Assumes it is included by bare name from the design files only.
*/
`ifndef TX_ALARM_REGS_VH
`define TX_ALARM_REGS_VH

// Byte offsets on the management bus page
`define OFS_SUMMARY_STATUS   8'h02
`define OFS_LOS_HIGH_CH      8'h09
`define OFS_LOS_LOW_CH       8'h0A
`define OFS_FAULT_HIGH_CH    8'h0B
`define OFS_FAULT_LOW_CH     8'h0C
`define OFS_TEMP_ALARM       8'h0D
`define OFS_SUPPLY_ALARM     8'h0E
`define OFS_RESERVED_15      8'h0F
`define OFS_BIAS_CH11_CH10   8'h10
`define OFS_BIAS_CH9_CH8     8'h11
`define OFS_BIAS_CH7_CH6     8'h12
`define OFS_BIAS_CH5_CH4     8'h13
`define OFS_BIAS_CH3_CH2     8'h14
`define OFS_BIAS_CH1_CH0     8'h15
`define OFS_POWER_CH11_CH10  8'h16
`define OFS_POWER_CH9_CH8    8'h17

// Summary byte fields
`define BIT_SUM_FAULT        3
`define BIT_SUM_LOS          2
`define BIT_SUM_INT          1
`define BIT_SUM_NOT_READY    0

// Two-channel alarm byte fields: higher channel in the upper nibble
`define BIT_PAIR_HI_HIGH     7
`define BIT_PAIR_HI_LOW      6
`define BIT_PAIR_LO_HIGH     3
`define BIT_PAIR_LO_LOW      2

// Temperature and supply fields
`define BIT_TEMP_HIGH        7
`define BIT_TEMP_LOW         6
`define BIT_V33_HIGH         7
`define BIT_V33_LOW          6
`define BIT_V25_HIGH         3
`define BIT_V25_LOW          2

// Reset values
`define RST_FLAGS            1'b0
`define RST_BYTE             8'h00
`define RST_POINTER          8'h00
`define RST_INT_N            1'b1

// Bus device address, arbitrary value
`define DEV_ADDR_DEFAULT     7'h2A

// Longest time from end of a clearing read to the interrupt release
`define FLAG_CLEAR_TIME_MS   100
`define CLK_PERIOD_PS        4000
`define FLAG_CLEAR_CYCLES    ((`FLAG_CLEAR_TIME_MS * 64'h3B9ACA00) / `CLK_PERIOD_PS)

`endif

// >>> verilog/flag_latch.v
/*
  A group of sticky alarm flags: each bit sets while its condition is
  present and holds until cleared.
  Assumes conditions and clear strobes are synchronous to CLK_SYS.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tx_alarm_regs.vh"

module flag_latch #(
  parameter WIDTH = 8
) (
  input  wire             CLK_SYS,
  input  wire             RESET_N,
  input  wire [WIDTH-1:0] COND,
  input  wire [WIDTH-1:0] CLR,
  output wire [WIDTH-1:0] FLAGS
);

  reg  [WIDTH-1:0] flags_q;
  wire [WIDTH-1:0] flags_d;

  // A condition present in the clearing cycle keeps the bit set
  assign flags_d = COND | (flags_q & ~CLR);

  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      flags_q <= {WIDTH{`RST_FLAGS}};
    else
      flags_q <= flags_d;
  end

  assign FLAGS = flags_q;

endmodule

`default_nettype wire

// >>> verilog/tx_alarm_flags.v
/*
  Latched clear-on-read alarm flag bytes of a twelve-channel transmitter,
  served on the two-wire management bus (pointer write, then reads with
  auto-increment), with the summary byte and the active-low interrupt.
  Assumes SCL and SDA inputs are already synchronous to CLK_SYS and slow
  against it; SDA is open drain, pulled low while SDA_OE is high.
*/
// Notes on behaviour
// - Byte 10 low bits: loss flags ch4-0
// - Flags latch on condition, clear on read
// - Byte 11: zero nibble, faults ch11-8
// - Byte 12: fault flags ch7-0
// - Byte 13: temperature high/low alarms, rest zero
// - Byte 14 upper: 3.3 V high/low
// - Byte 14 lower: 2.5 V high/low
// - Bytes 16-21: bias alarms, two channels each
// - Bytes 22-23: power alarms, same layout
// - Byte 9 loss ch11-8; byte 10 ch7-5
// - Summary fault bit follows any fault flag
// - Interrupt status until all flags clear
// - Interrupt releases promptly after clearing read
`timescale 1ns/1ps
`default_nettype none
`include "tx_alarm_regs.vh"

module tx_alarm_flags #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
  input  wire        CLK_SYS,
  input  wire        RESET_N,
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE,
  input  wire [11:0] LOS_COND,
  input  wire [11:0] FAULT_COND,
  input  wire        TEMP_HIGH_COND,
  input  wire        TEMP_LOW_COND,
  input  wire        V33_HIGH_COND,
  input  wire        V33_LOW_COND,
  input  wire        V25_HIGH_COND,
  input  wire        V25_LOW_COND,
  input  wire [11:0] BIAS_HIGH_COND,
  input  wire [11:0] BIAS_LOW_COND,
  input  wire [3:0]  POWER_HIGH_COND,
  input  wire [3:0]  POWER_LOW_COND,
  output wire        INT_N
);

  localparam [6:0] S_IDLE      = 7'h01;
  localparam [6:0] S_ADDR      = 7'h02;
  localparam [6:0] S_ADDR_ACK  = 7'h04;
  localparam [6:0] S_WRITE     = 7'h08;
  localparam [6:0] S_WRITE_ACK = 7'h10;
  localparam [6:0] S_READ      = 7'h20;
  localparam [6:0] S_READ_ACK  = 7'h40;

  reg  [6:0]  state_q;
  reg  [3:0]  cnt_q;
  reg  [7:0]  shift_q, tx_q, snap_q, ptr_q, clr_addr_q, clr_mask_q;
  reg         scl_q, sda_q, ptr_phase_q, rw_q, nack_q, oe_q, clr_go_q, int_n_q;

  wire [11:0] los, fault, bias_hi, bias_lo;
  wire [3:0]  supply, pwr_hi, pwr_lo;
  wire [1:0]  temp;

  reg  [11:0] clr_los, clr_fault, clr_bias_hi, clr_bias_lo;
  reg  [3:0]  clr_supply, clr_pwr_hi, clr_pwr_lo;
  reg  [1:0]  clr_temp;
  reg  [7:0]  rd_byte;

  wire scl_rise = SCL_IN & ~scl_q;
  wire scl_fall = ~SCL_IN & scl_q;
  wire start    = scl_q & SCL_IN & sda_q & ~SDA_IN;
  wire stop     = scl_q & SCL_IN & ~sda_q & SDA_IN;
  wire any_flag = (|los) | (|fault) | (|temp) | (|supply) | (|bias_hi) | (|bias_lo) | (|pwr_hi) | (|pwr_lo);

  // Clear bits of a two-channel byte: both high alarms, then both low alarms
  wire [3:0] clr_pair = {clr_mask_q[`BIT_PAIR_HI_HIGH], clr_mask_q[`BIT_PAIR_LO_HIGH],
                         clr_mask_q[`BIT_PAIR_HI_LOW], clr_mask_q[`BIT_PAIR_LO_LOW]};

  // Packs one two-channel alarm byte; middle and bottom bit pairs read zero
  function [7:0] pair_byte;
    input hh;
    input hl;
    input lh;
    input ll;
    begin
      pair_byte = 8'h00;
      pair_byte[`BIT_PAIR_HI_HIGH] = hh;
      pair_byte[`BIT_PAIR_HI_LOW]  = hl;
      pair_byte[`BIT_PAIR_LO_HIGH] = lh;
      pair_byte[`BIT_PAIR_LO_LOW]  = ll;
    end
  endfunction

  flag_latch #(.WIDTH(12)) u_los (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .COND(LOS_COND), .CLR(clr_los), .FLAGS(los));
  flag_latch #(.WIDTH(12)) u_fault (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .COND(FAULT_COND), .CLR(clr_fault), .FLAGS(fault));
  flag_latch #(.WIDTH(2)) u_temp (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .COND({TEMP_HIGH_COND, TEMP_LOW_COND}), .CLR(clr_temp), .FLAGS(temp));
  flag_latch #(.WIDTH(4)) u_supply (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .COND({V33_HIGH_COND, V33_LOW_COND, V25_HIGH_COND, V25_LOW_COND}), .CLR(clr_supply), .FLAGS(supply));
  flag_latch #(.WIDTH(12)) u_bias_hi (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .COND(BIAS_HIGH_COND), .CLR(clr_bias_hi), .FLAGS(bias_hi));
  flag_latch #(.WIDTH(12)) u_bias_lo (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .COND(BIAS_LOW_COND), .CLR(clr_bias_lo), .FLAGS(bias_lo));
  flag_latch #(.WIDTH(4)) u_pwr_hi (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .COND(POWER_HIGH_COND), .CLR(clr_pwr_hi), .FLAGS(pwr_hi));
  flag_latch #(.WIDTH(4)) u_pwr_lo (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .COND(POWER_LOW_COND), .CLR(clr_pwr_lo), .FLAGS(pwr_lo));

  // Byte view at the pointer; unlisted offsets read zero without side effect
  always @*
  begin
    rd_byte = `RST_BYTE;
    case (ptr_q)
      `OFS_SUMMARY_STATUS:
      begin
        rd_byte[`BIT_SUM_FAULT]     = |fault;
        rd_byte[`BIT_SUM_LOS]       = |los;
        rd_byte[`BIT_SUM_INT]       = ~int_n_q;
        rd_byte[`BIT_SUM_NOT_READY] = 1'b0;
      end
      `OFS_LOS_HIGH_CH:     rd_byte = {4'h0, los[11:8]};
      `OFS_LOS_LOW_CH:      rd_byte = los[7:0];
      `OFS_FAULT_HIGH_CH:   rd_byte = {4'h0, fault[11:8]};
      `OFS_FAULT_LOW_CH:    rd_byte = fault[7:0];
      `OFS_TEMP_ALARM:
      begin
        rd_byte[`BIT_TEMP_HIGH] = temp[1];
        rd_byte[`BIT_TEMP_LOW]  = temp[0];
      end
      `OFS_SUPPLY_ALARM:
      begin
        rd_byte[`BIT_V33_HIGH] = supply[3];
        rd_byte[`BIT_V33_LOW]  = supply[2];
        rd_byte[`BIT_V25_HIGH] = supply[1];
        rd_byte[`BIT_V25_LOW]  = supply[0];
      end
      `OFS_RESERVED_15:     rd_byte = `RST_BYTE;
      `OFS_BIAS_CH11_CH10:  rd_byte = pair_byte(bias_hi[11], bias_lo[11], bias_hi[10], bias_lo[10]);
      `OFS_BIAS_CH9_CH8:    rd_byte = pair_byte(bias_hi[9], bias_lo[9], bias_hi[8], bias_lo[8]);
      `OFS_BIAS_CH7_CH6:    rd_byte = pair_byte(bias_hi[7], bias_lo[7], bias_hi[6], bias_lo[6]);
      `OFS_BIAS_CH5_CH4:    rd_byte = pair_byte(bias_hi[5], bias_lo[5], bias_hi[4], bias_lo[4]);
      `OFS_BIAS_CH3_CH2:    rd_byte = pair_byte(bias_hi[3], bias_lo[3], bias_hi[2], bias_lo[2]);
      `OFS_BIAS_CH1_CH0:    rd_byte = pair_byte(bias_hi[1], bias_lo[1], bias_hi[0], bias_lo[0]);
      `OFS_POWER_CH11_CH10: rd_byte = pair_byte(pwr_hi[3], pwr_lo[3], pwr_hi[2], pwr_lo[2]);
      `OFS_POWER_CH9_CH8:   rd_byte = pair_byte(pwr_hi[1], pwr_lo[1], pwr_hi[0], pwr_lo[0]);
      default:              rd_byte = `RST_BYTE;
    endcase
  end

  // Only bits that were shipped as 1 are cleared, so a flag rising after
  // the byte was captured survives for the next read
  always @*
  begin
    clr_los     = 12'h000;
    clr_fault   = 12'h000;
    clr_temp    = 2'h0;
    clr_supply  = 4'h0;
    clr_bias_hi = 12'h000;
    clr_bias_lo = 12'h000;
    clr_pwr_hi  = 4'h0;
    clr_pwr_lo  = 4'h0;
    if (clr_go_q)
    begin
      case (clr_addr_q)
        `OFS_LOS_HIGH_CH:   clr_los[11:8]  = clr_mask_q[3:0];
        `OFS_LOS_LOW_CH:    clr_los[7:0]   = clr_mask_q;
        `OFS_FAULT_HIGH_CH: clr_fault[11:8] = clr_mask_q[3:0];
        `OFS_FAULT_LOW_CH:  clr_fault[7:0]  = clr_mask_q;
        `OFS_TEMP_ALARM:    clr_temp = {clr_mask_q[`BIT_TEMP_HIGH], clr_mask_q[`BIT_TEMP_LOW]};
        `OFS_SUPPLY_ALARM:
          clr_supply = {clr_mask_q[`BIT_V33_HIGH], clr_mask_q[`BIT_V33_LOW],
                        clr_mask_q[`BIT_V25_HIGH], clr_mask_q[`BIT_V25_LOW]};
        `OFS_BIAS_CH11_CH10:  {clr_bias_hi[11:10], clr_bias_lo[11:10]} = clr_pair;
        `OFS_BIAS_CH9_CH8:    {clr_bias_hi[9:8], clr_bias_lo[9:8]} = clr_pair;
        `OFS_BIAS_CH7_CH6:    {clr_bias_hi[7:6], clr_bias_lo[7:6]} = clr_pair;
        `OFS_BIAS_CH5_CH4:    {clr_bias_hi[5:4], clr_bias_lo[5:4]} = clr_pair;
        `OFS_BIAS_CH3_CH2:    {clr_bias_hi[3:2], clr_bias_lo[3:2]} = clr_pair;
        `OFS_BIAS_CH1_CH0:    {clr_bias_hi[1:0], clr_bias_lo[1:0]} = clr_pair;
        `OFS_POWER_CH11_CH10: {clr_pwr_hi[3:2], clr_pwr_lo[3:2]} = clr_pair;
        `OFS_POWER_CH9_CH8:   {clr_pwr_hi[1:0], clr_pwr_lo[1:0]} = clr_pair;
        default:              clr_los = 12'h000;
      endcase
    end
  end

  // Bus slave: bits sampled on SCL rise, SDA changed on SCL fall
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q     <= S_IDLE;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      cnt_q       <= 4'h0;
      shift_q     <= `RST_BYTE;
      tx_q        <= `RST_BYTE;
      snap_q      <= `RST_BYTE;
      ptr_q       <= `RST_POINTER;
      ptr_phase_q <= 1'b0;
      rw_q        <= 1'b0;
      nack_q      <= 1'b0;
      oe_q        <= 1'b0;
      clr_go_q    <= 1'b0;
      clr_addr_q  <= `RST_BYTE;
      clr_mask_q  <= `RST_BYTE;
    end
    else
    begin
      scl_q    <= SCL_IN;
      sda_q    <= SDA_IN;
      clr_go_q <= 1'b0;
      if (start)
      begin
        state_q <= S_ADDR;
        cnt_q   <= 4'h0;
        oe_q    <= 1'b0;
      end
      else if (stop)
      begin
        state_q <= S_IDLE;
        oe_q    <= 1'b0;
      end
      else
      begin
        case (state_q)
          S_IDLE:
          begin
            oe_q <= 1'b0;
          end
          S_ADDR, S_WRITE:
          begin
            if (scl_rise && cnt_q != 4'h8)
            begin
              shift_q <= {shift_q[6:0], SDA_IN};
              cnt_q   <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == 4'h8)
            begin
              cnt_q <= 4'h0;
              if (state_q == S_WRITE)
              begin
                oe_q    <= 1'b1;
                state_q <= S_WRITE_ACK;
                if (ptr_phase_q)
                  ptr_q <= shift_q;
                ptr_phase_q <= 1'b0;
              end
              else if (shift_q[7:1] == DEV_ADDR)
              begin
                oe_q    <= 1'b1;
                rw_q    <= shift_q[0];
                state_q <= S_ADDR_ACK;
              end
              else
                state_q <= S_IDLE;
            end
          end
          S_ADDR_ACK:
          begin
            if (scl_fall)
            begin
              if (rw_q)
              begin
                tx_q    <= rd_byte;
                snap_q  <= rd_byte;
                oe_q    <= ~rd_byte[7];
                state_q <= S_READ;
              end
              else
              begin
                oe_q        <= 1'b0;
                ptr_phase_q <= 1'b1;
                state_q     <= S_WRITE;
              end
            end
          end
          S_WRITE_ACK:
          begin
            // Data bytes after the pointer are acknowledged and dropped
            if (scl_fall)
            begin
              oe_q    <= 1'b0;
              state_q <= S_WRITE;
            end
          end
          S_READ:
          begin
            if (scl_fall)
            begin
              if (cnt_q == 4'h7)
              begin
                cnt_q   <= 4'h0;
                oe_q    <= 1'b0;
                state_q <= S_READ_ACK;
              end
              else
              begin
                cnt_q <= cnt_q + 4'h1;
                tx_q  <= {tx_q[6:0], 1'b0};
                oe_q  <= ~tx_q[6];
              end
            end
          end
          S_READ_ACK:
          begin
            if (scl_rise)
            begin
              clr_go_q   <= 1'b1;
              clr_addr_q <= ptr_q;
              clr_mask_q <= snap_q;
              ptr_q      <= ptr_q + 8'h01;
              nack_q     <= SDA_IN;
            end
            else if (scl_fall)
            begin
              if (nack_q)
                state_q <= S_IDLE;
              else
              begin
                tx_q    <= rd_byte;
                snap_q  <= rd_byte;
                oe_q    <= ~rd_byte[7];
                state_q <= S_READ;
              end
            end
          end
          default:
          begin
            state_q <= S_IDLE;
            oe_q    <= 1'b0;
          end
        endcase
      end
    end
  end

  // Interrupt releases one cycle after the last flag clears, far inside the limit
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      int_n_q <= `RST_INT_N;
    else
      int_n_q <= ~any_flag;
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE  = oe_q;
  assign INT_N   = int_n_q;

endmodule

`default_nettype wire

// >>> tb/tx_alarm_flags_props.sv
/*
  Checker for the latched alarm flag bank: bus answer timing and the
  causes of every change on the interrupt line.
  Assumes it is bound to tx_alarm_flags and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module tx_alarm_flags_props (
  input wire logic        CLK_SYS,
  input wire logic        RESET_N,
  input wire logic        SCL_IN,
  input wire logic        SDA_IN,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE,
  input wire logic [11:0] LOS_COND,
  input wire logic [11:0] FAULT_COND,
  input wire logic        TEMP_HIGH_COND,
  input wire logic        TEMP_LOW_COND,
  input wire logic        V33_HIGH_COND,
  input wire logic        V33_LOW_COND,
  input wire logic        V25_HIGH_COND,
  input wire logic        V25_LOW_COND,
  input wire logic [11:0] BIAS_HIGH_COND,
  input wire logic [11:0] BIAS_LOW_COND,
  input wire logic [3:0]  POWER_HIGH_COND,
  input wire logic [3:0]  POWER_LOW_COND,
  input wire logic        INT_N
);
  wire any_cond = |{LOS_COND, FAULT_COND, TEMP_HIGH_COND, TEMP_LOW_COND, V33_HIGH_COND, V33_LOW_COND,
                    V25_HIGH_COND, V25_LOW_COND, BIAS_HIGH_COND, BIAS_LOW_COND, POWER_HIGH_COND, POWER_LOW_COND};

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  chk_sda_open_drain: assert property (SDA_OUT == 1'b0)
    else $error("data output value not low");
  chk_reset_idle: assert property ($rose(RESET_N) |-> INT_N && !SDA_OE)
    else $error("bus or interrupt active at reset release");
  chk_oe_stands_high: assert property (SCL_IN |-> $stable(SDA_OE))
    else $error("data output changed while bus clock high");
  chk_oe_answer_time: assert property ($rose(SDA_OE) |-> !SCL_IN &&
    ($past(SCL_IN, 2) || $past(SCL_IN, 3) || $past(SCL_IN, 4)))
    else $error("data output rose too late after bus clock fall");
  chk_int_follows_cond: assert property (any_cond |-> ##2 !INT_N)
    else $error("interrupt not low two cycles after a condition");
  chk_int_fall_cause: assert property ($fell(INT_N) |-> $past(any_cond, 2))
    else $error("interrupt fell without a condition");
  chk_int_release_read: assert property ($rose(INT_N) |-> SCL_IN && !$past(any_cond, 2))
    else $error("interrupt released outside a read ack slot");
  chk_int_persistent: assert property (any_cond [*3] |-> !INT_N)
    else $error("interrupt high while a condition persists");

  cov_int_set: cover property ($fell(INT_N));
  cov_int_clear: cover property ($rose(INT_N));
  cov_data_drive: cover property ($rose(SDA_OE));
endmodule

bind tx_alarm_flags tx_alarm_flags_props i_tx_alarm_flags_props (
  .CLK_SYS, .RESET_N, .SCL_IN, .SDA_IN, .SDA_OUT, .SDA_OE, .LOS_COND, .FAULT_COND,
  .TEMP_HIGH_COND, .TEMP_LOW_COND, .V33_HIGH_COND, .V33_LOW_COND, .V25_HIGH_COND, .V25_LOW_COND,
  .BIAS_HIGH_COND, .BIAS_LOW_COND, .POWER_HIGH_COND, .POWER_LOW_COND, .INT_N
);

`default_nettype wire

// >>> tb/tws_host_model.sv
/*
  Host controller model on the two-wire management bus: pointer write,
  repeated start, then a burst read acked on all bytes but the last.
  Assumes the bench adds the pull-up and feeds back the wire level.
*/
`timescale 1ns/1ps
`default_nettype none

module tws_host_model (
  input  wire logic CLK_SYS,
  input  wire logic SDA_IN,
  output var logic  SCL,
  output var logic  SDA_LOW
);
  // Half bus period in system clocks; the bench may slow the host down
  int half = 6;

  initial
  begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  // Data moves one clock after the bus clock fall, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    tick(1);
    SDA_LOW <= ~b;
    tick(half);
    SCL <= 1'b1;
    tick(half / 2);
    s = SDA_IN;
    tick(half - half / 2);
    SCL <= 1'b0;
  endtask

  task automatic start_cond;
    tick(1);
    SDA_LOW <= 1'b0;
    tick(half);
    SCL <= 1'b1;
    tick(half);
    SDA_LOW <= 1'b1;
    tick(half);
    SCL <= 1'b0;
  endtask

  task automatic stop_cond;
    tick(1);
    SDA_LOW <= 1'b1;
    tick(half);
    SCL <= 1'b1;
    tick(half);
    SDA_LOW <= 1'b0;
    tick(half);
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask

  task automatic read_seq(input logic [6:0] addr, input logic [7:0] ptr, input int n,
                          output logic [7:0] q [16], output logic ok);
    logic [7:0] d;
    logic       a;
    start_cond;
    byte_io({addr, 1'b0}, 1'b1, d, a);
    ok = ~a;
    if (ok)
    begin
      byte_io(ptr, 1'b1, d, a);
      start_cond;
      byte_io({addr, 1'b1}, 1'b1, d, a);
      ok = ~a;
      for (int i = 0; i < n; i++)
        byte_io(8'hFF, (i == n - 1), q[i], a);
    end
    stop_cond;
  endtask
endmodule

`default_nettype wire

// >>> tb/tx_alarm_flags_test.sv
/*
  Self-checking bench for the latched alarm flag bank: pulses and holds
  alarm conditions, reads the flag bytes through the host model.
  Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tx_alarm_flags_test;
  // Bus address, arbitrary value
  localparam logic [6:0] ADDR = 7'h35;
  localparam logic [61:0] PAT = 62'h2A5C3B6E9D147F08;

  logic        clk_sys;
  logic        reset_n;
  logic [61:0] cv;
  logic [61:0] ev;
  logic        scl;
  logic        sda_low;
  wire         sda_oe;
  wire         int_n;
  wire         sda_bus;
  logic [7:0]  q [16];
  logic        ok;
  int          mismatches;
  int          num_checks;

  assign sda_bus = ~(sda_low | sda_oe);

  tx_alarm_flags #(.DEV_ADDR(ADDR)) i_tx_alarm_flags (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda_bus), .SDA_OUT(), .SDA_OE(sda_oe),
    .LOS_COND(cv[61:50]), .FAULT_COND(cv[49:38]), .TEMP_HIGH_COND(cv[37]), .TEMP_LOW_COND(cv[36]),
    .V33_HIGH_COND(cv[35]), .V33_LOW_COND(cv[34]), .V25_HIGH_COND(cv[33]), .V25_LOW_COND(cv[32]),
    .BIAS_HIGH_COND(cv[31:20]), .BIAS_LOW_COND(cv[19:8]), .POWER_HIGH_COND(cv[7:4]),
    .POWER_LOW_COND(cv[3:0]), .INT_N(int_n));

  tws_host_model i_tws_host_model (.CLK_SYS(clk_sys), .SDA_IN(sda_bus), .SCL(scl), .SDA_LOW(sda_low));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Flag layout of ev follows the condition vector cv bit for bit
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    int h;
    h = 43 - 2 * int'(a);
    case (a)
      8'h02: exp_byte = {4'h0, |ev[49:38], |ev[61:50], |ev, 1'b0};
      8'h09: exp_byte = {4'h0, ev[61:58]};
      8'h0A: exp_byte = ev[57:50];
      8'h0B: exp_byte = {4'h0, ev[49:46]};
      8'h0C: exp_byte = ev[45:38];
      8'h0D: exp_byte = {ev[37:36], 6'h00};
      8'h0E: exp_byte = {ev[35:34], 2'b00, ev[33:32], 2'b00};
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15:
        exp_byte = {ev[20 + h], ev[8 + h], 2'b00, ev[19 + h], ev[7 + h], 2'b00};
      8'h16: exp_byte = {ev[7], ev[3], 2'b00, ev[6], ev[2], 2'b00};
      8'h17: exp_byte = {ev[5], ev[1], 2'b00, ev[4], ev[0], 2'b00};
      default: exp_byte = 8'h00;
    endcase
  endfunction

  task automatic wait_int(input logic val);
    int n;
    n = 0;
    while (int_n !== val && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    check("interrupt line", {7'h00, int_n}, {7'h00, val});
    if (int_n !== val)
      test_done;
  endtask

  task automatic rd_check(input logic [7:0] ptr, input int n);
    i_tws_host_model.read_seq(ADDR, ptr, n, q, ok);
    check("address ack", {7'h00, ok}, 8'h01);
    for (int i = 0; i < n; i++)
      check($sformatf("byte %0d", ptr + 8'(i)), q[i], exp_byte(ptr + 8'(i)));
  endtask

  // One cycle of conditions, so everything read afterwards is latched
  task automatic pulse(input logic [61:0] v);
    cv <= v;
    @(posedge clk_sys);
    cv <= '0;
    ev = v;
  endtask

  task automatic reset_values;
    check("interrupt line", {7'h00, int_n}, 8'h01);
    rd_check(8'h02, 1);
    rd_check(8'h09, 15);
  endtask

  task automatic map_pattern(input logic [61:0] v);
    pulse(v);
    wait_int(1'b0);
    rd_check(8'h02, 1);
    rd_check(8'h09, 15);
    ev = '0;
    wait_int(1'b1);
    rd_check(8'h02, 1);
    rd_check(8'h09, 15);
  endtask

  task automatic persistent_flags;
    cv <= 62'h1 << 49;
    ev = 62'h1 << 49;
    wait_int(1'b0);
    rd_check(8'h02, 1);
    rd_check(8'h0A, 2);
    rd_check(8'h0A, 2);
    cv <= '0;
    rd_check(8'h0A, 2);
    ev = '0;
    rd_check(8'h0A, 2);
    rd_check(8'h02, 1);
    wait_int(1'b1);
  endtask

  // With a slow host, a foreign address and the reserved byte must clear nothing
  task automatic refused_reads;
    i_tws_host_model.half = 12;
    pulse('1);
    i_tws_host_model.read_seq(ADDR ^ 7'h01, 8'h09, 1, q, ok);
    check("foreign address ack", {7'h00, ok}, 8'h00);
    rd_check(8'h0F, 1);
    rd_check(8'h09, 15);
    ev = '0;
    wait_int(1'b1);
    i_tws_host_model.half = 6;
  endtask

  initial
  begin
    reset_n = 1'b0;
    cv = '0;
    ev = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    reset_values;
    map_pattern(PAT);
    map_pattern(~PAT);
    persistent_flags;
    refused_reads;
    test_done;
  end
endmodule

`default_nettype wire
